/* File: verilog/cip_config_init.sv */
// startup sequencing, open-drain init done pin and device-wide pin overrides
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - restart pin low leaves init done pin undriven, pull-up holds it high.
// - once the enable option frame arrives, init done is pulled low.
// - initialization finished releases init done and enters user mode.
// - with calibration gating on, release waits for termination calibration complete.
// - global output enable low forces all pins tri-state when enabled.
// - global clear low clears all device registers when enabled.
// - startup clock option synchronises the user mode entry to that clock.
// - active serial scheme may take the serial clock from the startup clock.
// - each optional pin is plain user I/O unless its option is on.
module cip_config_init #(
    parameter int unsigned SERIAL_HALF = cip_pkg::SERIAL_HALF_CYC
) (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire logic [3:0]                   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic [31:0]                       avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic                         user_startup_clock,
    input  wire logic                         config_restart_n,
    input  wire logic                         global_output_enable,
    input  wire logic                         global_clear_n,
    input  wire logic                         init_done_in,
    output logic                              init_done_out,
    output logic                              init_done_oe,
    input  wire logic                         option_frame_pulse,
    input  wire logic                         init_complete_pulse,
    input  wire logic                         termination_cal_complete,
    input  wire logic                         user_init_done_out,
    input  wire logic                         user_init_done_oe,
    output logic [cip_pkg::OPT_COUNT-1:0]     user_pin_in,
    output logic [cip_pkg::OPT_COUNT-1:0]     dedicated_mask,
    output logic                              io_tristate_all,
    output logic                              register_clear,
    output logic                              config_serial_clock,
    output logic                              user_mode
);
    import cip_pkg::*;

    localparam int unsigned CW = (SERIAL_HALF < 2) ? 1 : $clog2(SERIAL_HALF);

    typedef struct packed {
        logic [CTRL_WIDTH-1:0] ctrl;
        cip_state_type         fsm;
        logic                  waitreq;
        logic [31:0]           rdata;
        logic                  usr_prev;
        logic                  sclk;
        logic [CW-1:0]         sclk_cnt;
        logic                  od_out;
        logic                  od_oe;
        logic                  tristate;
        logic                  clear;
        logic [OPT_COUNT-1:0]  user_in;
        logic [OPT_COUNT-1:0]  mask;
        logic                  in_user;
    } cip_top_state_type;

    cip_top_state_type state;
    cip_top_state_type next_state;

    // refuse a divider that the counter cannot serve;
    // a half period of one toggles the clock on every edge
    if (SERIAL_HALF < 1) begin : g_bad_half
        $error("serial clock half period must be at least one cycle");
    end

    // asynchronous pins pass two flops before any logic here
    cip_sync_if #(.WIDTH(PIN_COUNT)) pin_bus ();
    assign pin_bus.raw = {init_done_in, global_clear_n, global_output_enable,
                          config_restart_n, user_startup_clock};

    cip_pin_sync #(.WIDTH(PIN_COUNT)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pins    (pin_bus)
    );

    logic usr_s;
    logic restart_s;
    logic goe_s;
    logic gclr_s;
    logic init_in_s;
    assign usr_s     = pin_bus.synced[PIN_STARTUP];
    assign restart_s = pin_bus.synced[PIN_RESTART];
    assign goe_s     = pin_bus.synced[PIN_GOE];
    assign gclr_s    = pin_bus.synced[PIN_GCLR];
    assign init_in_s = pin_bus.synced[PIN_INIT_IN];

    logic init_en;
    logic cal_gate;
    logic startup_en;
    logic serial_src;
    logic goe_en;
    logic gclr_en;
    logic as_scheme;
    logic usr_rise;
    assign init_en    = state.ctrl[CTRL_INIT_DONE_EN];
    assign cal_gate   = state.ctrl[CTRL_CAL_GATE_EN];
    assign startup_en = state.ctrl[CTRL_STARTUP_EN];
    assign serial_src = state.ctrl[CTRL_SERIAL_SRC];
    assign goe_en     = state.ctrl[CTRL_GOE_EN];
    assign gclr_en    = state.ctrl[CTRL_GCLR_EN];
    assign as_scheme  = state.ctrl[CTRL_AS_SCHEME];
    assign usr_rise   = usr_s && !state.usr_prev;

    always_comb begin
        logic [31:0] status;
        logic        released;
        status     = '0;
        released   = 1'b0;
        next_state = state;

        // bus slave: answer one cycle after the request, then rearm
        next_state.waitreq = 1'b1;
        if ((avs_read || avs_write) && state.waitreq) begin
            next_state.waitreq = 1'b0;
        end
        status[STAT_STATE_LSB +: 3] = state.fsm;
        status[STAT_CAL_DONE]       = termination_cal_complete;
        status[STAT_RESTART_N]      = restart_s;
        status[STAT_GOE_PIN]        = goe_s;
        status[STAT_GCLR_N_PIN]     = gclr_s;
        status[STAT_DRIVE_LOW]      = state.od_oe && !state.od_out;
        status[STAT_USER_MODE]      = state.in_user;
        if (avs_read && state.waitreq) begin
            next_state.rdata = '0;  // unmapped reads return zero
            if (cip_hit(avs_address, CTRL_OFFSET)) begin
                next_state.rdata[CTRL_WIDTH-1:0] = state.ctrl;
            end else if (cip_hit(avs_address, STATUS_OFFSET)) begin
                next_state.rdata = status;
            end
        end
        // a write lands at the edge where waitrequest is seen low
        if (avs_write && !state.waitreq && avs_byteenable[0]
                && cip_hit(avs_address, CTRL_OFFSET)) begin
            next_state.ctrl = avs_writedata[CTRL_WIDTH-1:0];
        end

        // startup sequence
        next_state.usr_prev = usr_s;
        case (state.fsm)
            CIP_RESTART: begin
                next_state.fsm = CIP_LOAD;
            end
            CIP_LOAD: begin
                if (option_frame_pulse) begin
                    next_state.fsm = CIP_INIT;
                end
            end
            CIP_INIT: begin
                if (init_complete_pulse) begin
                    next_state.fsm = cal_gate ? CIP_CAL : CIP_SYNC;
                end
            end
            CIP_CAL: begin
                if (termination_cal_complete) begin
                    next_state.fsm = CIP_SYNC;
                end
            end
            CIP_SYNC: begin
                // several devices sharing one startup clock enter user mode together
                if (!startup_en || usr_rise) begin
                    next_state.fsm = CIP_USER;
                end
            end
            CIP_USER: begin
                next_state.fsm = CIP_USER;
            end
            default: begin
                next_state.fsm = CIP_RESTART;
            end
        endcase
        // sync bypass: INIT goes straight to USER in one step when gating and the startup clock option are both off
        if (state.fsm == CIP_INIT && init_complete_pulse && !cal_gate
                && !startup_en) begin
            next_state.fsm = CIP_USER;
        end
        if (!restart_s) begin
            next_state.fsm = CIP_RESTART;
        end
        next_state.in_user = (next_state.fsm == CIP_USER);

        // open-drain pin with its option on: low drive only in INIT, CAL and SYNC, released otherwise; option off passes the user drive
        released = (next_state.fsm == CIP_RESTART) || (next_state.fsm == CIP_LOAD)
                   || (next_state.fsm == CIP_USER);
        if (init_en) begin
            next_state.od_out = 1'b0;
            next_state.od_oe  = !released;
        end else begin
            next_state.od_out = user_init_done_out;
            next_state.od_oe  = user_init_done_oe;
        end

        // device-wide overrides only when their option is on
        next_state.tristate = goe_en && !goe_s;
        next_state.clear    = gclr_en && !gclr_s;

        // optional pins read as user inputs when their option is off
        next_state.mask[OPT_STARTUP]    = startup_en;
        next_state.mask[OPT_INIT]       = init_en;
        next_state.mask[OPT_GOE]        = goe_en;
        next_state.mask[OPT_GCLR]       = gclr_en;
        next_state.user_in[OPT_STARTUP] = !startup_en && usr_s;
        next_state.user_in[OPT_INIT]    = !init_en && init_in_s;
        next_state.user_in[OPT_GOE]     = !goe_en && goe_s;
        next_state.user_in[OPT_GCLR]    = !gclr_en && gclr_s;

        // serial clock: internal divider or the startup clock pin
        if (as_scheme && serial_src && startup_en) begin
            next_state.sclk     = usr_s;
            next_state.sclk_cnt = '0;
        end else if (state.sclk_cnt == CW'(SERIAL_HALF - 1)) begin
            next_state.sclk     = !state.sclk;
            next_state.sclk_cnt = '0;
        end else begin
            next_state.sclk_cnt = state.sclk_cnt + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state          <= '0;
            state.ctrl     <= CTRL_RESET;
            state.fsm      <= CIP_RESTART;
            state.waitreq  <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // every output comes straight from the state flops
    assign avs_readdata        = state.rdata;
    assign avs_waitrequest     = state.waitreq;
    assign init_done_out       = state.od_out;
    assign init_done_oe        = state.od_oe;
    assign user_pin_in         = state.user_in;
    assign dedicated_mask      = state.mask;
    assign io_tristate_all     = state.tristate;
    assign register_clear      = state.clear;
    assign config_serial_clock = state.sclk;
    assign user_mode           = state.in_user;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_bus_request;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence s_frame_seen;
        init_en && restart_s && state.fsm == CIP_LOAD && option_frame_pulse;
    endsequence

    sequence s_drive_low;
        init_done_oe && !init_done_out;
    endsequence

    a_bus_answer_once: assert property (s_bus_request |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not a single cycle");

    a_restart_release: assert property (init_en && !restart_s |=> !init_done_oe)
        else $error("init done driven during restart");

    a_frame_drive_low: assert property (s_frame_seen ##1 (restart_s && init_en) |-> s_drive_low)
        else $error("init done not pulled low after option frame");

    a_finish_release: assert property (state.fsm == CIP_INIT && init_complete_pulse && !cal_gate
            && !startup_en && restart_s |=> user_mode && state.fsm == CIP_USER)
        else $error("init finish did not enter user mode");

    a_user_released: assert property (user_mode && $past(init_en) |-> !init_done_oe)
        else $error("init done still driven in user mode");

    a_cal_gate_hold: assert property (state.fsm == CIP_CAL && !termination_cal_complete
            |=> !user_mode)
        else $error("release passed calibration gate");

    a_cal_not_gated: assert property (state.fsm == CIP_INIT && init_complete_pulse && !cal_gate
            && restart_s |=> state.fsm != CIP_CAL)
        else $error("calibration waited with gating off");

    a_goe_tristate: assert property (goe_en ##0 !goe_s |=> io_tristate_all)
        else $error("global output enable low did not tri-state");

    a_gclr_clear: assert property (gclr_s || !gclr_en |=> !register_clear)
        else $error("register clear without enabled low pin");

    a_startup_wait: assert property (state.fsm == CIP_SYNC && startup_en && !usr_rise && restart_s
            |=> state.fsm == CIP_SYNC)
        else $error("user mode entered off the startup clock edge");

    a_serial_source: assert property (as_scheme && serial_src && startup_en
            |=> config_serial_clock == $past(usr_s))
        else $error("serial clock not taken from startup clock");

    a_user_io_pass: assert property (!init_en |=> init_done_oe == $past(user_init_done_oe))
        else $error("init done pin not user I/O with option off");

    a_open_drain: assert property (init_en |=> !init_done_out)
        else $error("init done driven high");
endmodule
`default_nettype wire

/* File: verilog/cip_pkg.sv */
// constants, register map and state encoding for the config init pin control block
package cip_pkg;

    // clock rate and serial clock rate
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned SERIAL_CLK_HZ   = 1_000_000;
    localparam int unsigned SERIAL_HALF_CYC = CLK_HZ / (2 * SERIAL_CLK_HZ);

    // register byte offsets
    localparam logic [3:0] CTRL_OFFSET   = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;

    // control register field positions
    localparam int unsigned CTRL_INIT_DONE_EN = 0;
    localparam int unsigned CTRL_CAL_GATE_EN  = 1;
    localparam int unsigned CTRL_STARTUP_EN   = 2;
    localparam int unsigned CTRL_SERIAL_SRC   = 3;
    localparam int unsigned CTRL_GOE_EN       = 4;
    localparam int unsigned CTRL_GCLR_EN      = 5;
    localparam int unsigned CTRL_AS_SCHEME    = 6;
    localparam int unsigned CTRL_WIDTH        = 7;
    localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 7'h00;

    // status register field positions
    localparam int unsigned STAT_STATE_LSB  = 0;
    localparam int unsigned STAT_CAL_DONE   = 3;
    localparam int unsigned STAT_RESTART_N  = 4;
    localparam int unsigned STAT_GOE_PIN    = 5;
    localparam int unsigned STAT_GCLR_N_PIN = 6;
    localparam int unsigned STAT_DRIVE_LOW  = 7;
    localparam int unsigned STAT_USER_MODE  = 8;

    // synchronised pin indices
    localparam int unsigned PIN_STARTUP  = 0;
    localparam int unsigned PIN_RESTART  = 1;
    localparam int unsigned PIN_GOE      = 2;
    localparam int unsigned PIN_GCLR     = 3;
    localparam int unsigned PIN_INIT_IN  = 4;
    localparam int unsigned PIN_COUNT    = 5;

    // optional pin indices in the dedicated mask and user input vector
    localparam int unsigned OPT_STARTUP = 0;
    localparam int unsigned OPT_INIT    = 1;
    localparam int unsigned OPT_GOE     = 2;
    localparam int unsigned OPT_GCLR    = 3;
    localparam int unsigned OPT_COUNT   = 4;

    // startup sequence states
    typedef enum logic [2:0] {
        CIP_RESTART,
        CIP_LOAD,
        CIP_INIT,
        CIP_CAL,
        CIP_SYNC,
        CIP_USER
    } cip_state_type;

    // exact match of a byte address against a register offset
    function automatic logic cip_hit(input logic [3:0] addr, input logic [3:0] offset);
        cip_hit = (addr == offset);
    endfunction

endpackage

/* File: verilog/cip_sync_if.sv */
// carrier between the pin synchroniser and the control logic
`timescale 1ns/1ps
`default_nettype none
interface cip_sync_if #(
    parameter int unsigned WIDTH = 5
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    // synchroniser side
    modport sync (input raw, output synced);
    // control side
    modport user (output raw, input synced);
endinterface
`default_nettype wire

/* File: verilog/cip_pin_sync.sv */
// two-flop synchroniser for the asynchronous configuration pins
`timescale 1ns/1ps
`default_nettype none
module cip_pin_sync #(
    parameter int unsigned WIDTH = 5
) (
    input  wire logic  clk,
    input  wire logic  reset_n,
    cip_sync_if.sync   pins
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } cip_sync_state_type;

    cip_sync_state_type state;
    cip_sync_state_type next_state;

    // refuse an empty pin vector at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("cip_pin_sync needs at least one pin");
    end

    // first stage only feeds the second
    always_comb begin
        next_state        = state;
        next_state.first  = pins.raw;
        next_state.second = state.first;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pins.synced = state.second;
endmodule
`default_nettype wire

/* File: verification/cip_board.sv */
// board model: pull-up on the init done pin and a monitor of its rising edges
`timescale 1ns/1ps
`default_nettype none
module cip_board (
    input  wire logic       clk,
    input  wire logic       init_done_out,
    input  wire logic       init_done_oe,
    output logic            init_done_level,
    output logic [7:0]      rise_count
);
    logic       prev_level = 1'b1;
    logic [7:0] rises      = 8'h00;

    // open-drain wire: only a low drive wins, otherwise the pull-up holds it high
    assign init_done_level = (init_done_oe && !init_done_out) ? 1'b0 : 1'b1;

    // completion counts only as a low-to-high edge, a static high means nothing
    always @(posedge clk) begin
        if (!prev_level && init_done_level) begin
            rises <= rises + 8'h01;
        end
        prev_level <= init_done_level;
    end

    // one driver for the count, kept in a local variable
    assign rise_count = rises;
endmodule
`default_nettype wire

/* File: verification/config_init_pin_control_tb.sv */
// self-checking bench for the config init pin control block
`timescale 1ns/1ps
`default_nettype none
module config_init_pin_control_tb;
    import cip_pkg::*;

    logic        clk                      = 1'b0;
    logic        reset_n                  = 1'b0;
    logic [3:0]  avs_address              = 4'h0;
    logic        avs_read                 = 1'b0;
    logic        avs_write                = 1'b0;
    logic [31:0] avs_writedata            = 32'h0;
    logic [3:0]  avs_byteenable           = 4'h0;
    logic        user_startup_clock       = 1'b0;
    logic        config_restart_n         = 1'b0;
    logic        global_output_enable     = 1'b1;
    logic        global_clear_n           = 1'b1;
    logic        option_frame_pulse       = 1'b0;
    logic        init_complete_pulse      = 1'b0;
    logic        termination_cal_complete = 1'b0;
    logic        user_init_done_out       = 1'b0;
    logic        user_init_done_oe        = 1'b0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        init_done_out;
    logic        init_done_oe;
    logic        init_done_level;
    logic [3:0]  user_pin_in;
    logic [3:0]  dedicated_mask;
    logic        io_tristate_all;
    logic        register_clear;
    logic        config_serial_clock;
    logic        user_mode;
    logic [7:0]  rise_count;
    logic [7:0]  rise_base;
    int          n_mismatch               = 0;
    int          samples_checked          = 0;

    // free-running 10 MHz clock
    always #50 clk = ~clk;

    cip_config_init i_dut (
        .clk                      (clk),
        .reset_n                  (reset_n),
        .avs_address              (avs_address),
        .avs_read                 (avs_read),
        .avs_write                (avs_write),
        .avs_writedata            (avs_writedata),
        .avs_byteenable           (avs_byteenable),
        .avs_readdata             (avs_readdata),
        .avs_waitrequest          (avs_waitrequest),
        .user_startup_clock       (user_startup_clock),
        .config_restart_n         (config_restart_n),
        .global_output_enable     (global_output_enable),
        .global_clear_n           (global_clear_n),
        .init_done_in             (init_done_level),
        .init_done_out            (init_done_out),
        .init_done_oe             (init_done_oe),
        .option_frame_pulse       (option_frame_pulse),
        .init_complete_pulse      (init_complete_pulse),
        .termination_cal_complete (termination_cal_complete),
        .user_init_done_out       (user_init_done_out),
        .user_init_done_oe        (user_init_done_oe),
        .user_pin_in              (user_pin_in),
        .dedicated_mask           (dedicated_mask),
        .io_tristate_all          (io_tristate_all),
        .register_clear           (register_clear),
        .config_serial_clock      (config_serial_clock),
        .user_mode                (user_mode)
    );

    // the board resolves the open-drain pin and feeds it back
    cip_board i_board (
        .clk             (clk),
        .init_done_out   (init_done_out),
        .init_done_oe    (init_done_oe),
        .init_done_level (init_done_level),
        .rise_count      (rise_count)
    );

    task automatic end_sim();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one bus transfer; waitrequest is read before the edge's own updates land
    task automatic bus(input logic is_wr, input logic [3:0] addr, input logic [31:0] data,
                       input logic [3:0] be, output logic [31:0] rdata);
        int n;
        @(posedge clk);
        avs_address    <= addr;
        avs_writedata  <= data;
        avs_byteenable <= be;
        avs_write      <= is_wr;
        avs_read       <= !is_wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [3:0] addr, input logic [31:0] data, input logic [3:0] be);
        logic [31:0] d;
        bus(1'b1, addr, data, be, d);
    endtask

    task automatic rd_chk(input logic [3:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, addr, 32'h0, 4'hf, d);
        chk(d, exp);
    endtask

    // restart, then the enable-option frame; pin must stay released until it
    task automatic boot();
        config_restart_n <= 1'b0;
        cyc(4);
        config_restart_n <= 1'b1;
        cyc(6);
        chk(init_done_oe, 32'h0);
        option_frame_pulse <= 1'b1;
        cyc(1);
        option_frame_pulse <= 1'b0;
        cyc(2);
    endtask

    task automatic finish_init();
        init_complete_pulse <= 1'b1;
        cyc(1);
        init_complete_pulse <= 1'b0;
        cyc(3);
    endtask

    // hang guard
    initial begin
        cyc(20000);
        n_mismatch++;
        end_sim();
    end

    initial begin
        cyc(20);
        reset_n <= 1'b1;
        cyc(4);
        // reset values with restart held low
        chk(init_done_oe, 32'h0);
        chk(user_pin_in, 32'he);
        rd_chk(CTRL_OFFSET, {25'h0, CTRL_RESET});
        rd_chk(STATUS_OFFSET, 32'h60);
        rd_chk(4'h8, 32'h0);
        // lane 0 off leaves control alone; upper bits read as zero
        wr(CTRL_OFFSET, 32'hffffffff, 4'he);
        rd_chk(CTRL_OFFSET, 32'h0);
        wr(CTRL_OFFSET, 32'hffffffff, 4'hf);
        rd_chk(CTRL_OFFSET, 32'h7f);
        wr(CTRL_OFFSET, 32'h0, 4'hf);
        // options off: every optional pin is plain user I/O
        user_init_done_oe    <= 1'b1;
        user_startup_clock   <= 1'b1;
        global_output_enable <= 1'b0;
        global_clear_n       <= 1'b0;
        cyc(5);
        chk(init_done_oe, 32'h1);
        chk(init_done_level, 32'h0);
        chk(user_pin_in, 32'h1);
        chk(dedicated_mask, 32'h0);
        chk(io_tristate_all, 32'h0);
        chk(register_clear, 32'h0);
        // global pins dedicated and driven low
        wr(CTRL_OFFSET, 32'h30, 4'hf);
        cyc(4);
        chk(dedicated_mask, 32'hc);
        chk(io_tristate_all, 32'h1);
        chk(register_clear, 32'h1);
        chk(user_pin_in, 32'h1);
        global_output_enable <= 1'b1;
        global_clear_n       <= 1'b1;
        user_init_done_oe    <= 1'b0;
        user_startup_clock   <= 1'b0;
        cyc(4);
        chk(io_tristate_all, 32'h0);
        chk(register_clear, 32'h0);
        // plain start-up with the init done pin enabled
        wr(CTRL_OFFSET, 32'h01, 4'hf);
        rise_base = rise_count;
        boot();
        chk(init_done_oe, 32'h1);
        chk(init_done_out, 32'h0);
        chk(init_done_level, 32'h0);
        finish_init();
        chk(user_mode, 32'h1);
        chk(init_done_oe, 32'h0);
        chk(rise_count, rise_base + 8'h01);
        rd_chk(STATUS_OFFSET, 32'h175);
        config_restart_n <= 1'b0;
        cyc(4);
        chk(user_mode, 32'h0);
        chk(init_done_oe, 32'h0);
        rd_chk(STATUS_OFFSET, 32'h60);
        // calibration gating holds the release back
        wr(CTRL_OFFSET, 32'h03, 4'hf);
        boot();
        finish_init();
        cyc(4);
        chk(user_mode, 32'h0);
        chk(init_done_level, 32'h0);
        termination_cal_complete <= 1'b1;
        cyc(4);
        chk(user_mode, 32'h1);
        chk(init_done_level, 32'h1);
        termination_cal_complete <= 1'b0;
        // user mode waits for a rise of the startup clock
        wr(CTRL_OFFSET, 32'h05, 4'hf);
        boot();
        finish_init();
        cyc(4);
        chk(user_mode, 32'h0);
        user_startup_clock <= 1'b1;
        cyc(5);
        chk(user_mode, 32'h1);
        user_startup_clock <= 1'b0;
        // serial clock taken from the startup clock
        wr(CTRL_OFFSET, 32'h4c, 4'hf);
        user_startup_clock <= 1'b1;
        cyc(4);
        chk(config_serial_clock, 32'h1);
        cyc(5);
        chk(config_serial_clock, 32'h1);
        user_startup_clock <= 1'b0;
        cyc(4);
        chk(config_serial_clock, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
